/* inc/scm_params.svh */
// constants of the system clock and mode control block
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH
// ==========================================================
// register byte offsets
`define SCM_OFS_MODE        12'h000
`define SCM_OFS_CTRL        12'h004
`define SCM_OFS_IRQ_STAT    12'h008
`define SCM_OFS_IRQ_MASK    12'h00C
// ==========================================================
// mode select register fields
`define SCM_MODE_DIV_HI     7
`define SCM_MODE_DIV_LO     5
`define SCM_MODE_UNUSED     4
`define SCM_MODE_SLOW_RDY   3
`define SCM_MODE_FAST_RDY   2
`define SCM_MODE_IDLE_EN    1
`define SCM_MODE_HL_SEL     0
`define SCM_MODE_RESET      8'h03
// ==========================================================
// clock control register fields
`define SCM_CTRL_KEEP       7
`define SCM_CTRL_RC_HI      5
`define SCM_CTRL_RC_LO      4
`define SCM_CTRL_XLP        3
`define SCM_CTRL_RESET      8'h00
// ==========================================================
// interrupt bits
`define SCM_IRQ_FAST_RDY    0
`define SCM_IRQ_SLOW_RDY    1
`define SCM_IRQ_WAKE        2
`define SCM_IRQ_WIDTH       3
// ==========================================================
// stabilisation counts in oscillator cycles
`define SCM_FAST_STABLE     5'd16
`define SCM_XTAL_STABLE     8'd128
`define SCM_RC_STABLE       8'd2
// ==========================================================
// source codes: log2 of divisor, or slow clock
`define SCM_SRC_SLOW        3'd7
// rc frequency in mhz per select code
`define SCM_RC_MHZ_00       5'd8
`define SCM_RC_MHZ_01       5'd12
`define SCM_RC_MHZ_10       5'd16
`define SCM_RC_MHZ_11       5'd8
// operating mode codes on mode_o
`define SCM_OPM_FAST        3'd0
`define SCM_OPM_SLOW        3'd1
`define SCM_OPM_SLEEP       3'd2
`define SCM_OPM_IDLE_STOP   3'd3
`define SCM_OPM_IDLE_RUN    3'd4
`endif

/* inc/scm_pkg.sv */
// types of the system clock and mode control block
package scm_pkg;
  // ==========================================================
  // power state
  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_IDLE_CLOCK_STOPPED,
    ST_IDLE_CLOCK_RUNNING
  } scm_state_e;
  typedef logic [2:0] scm_src_t;
endpackage

/* sim/testbench.sv */
// self-checking testbench of the system clock and mode control block
`include "scm_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import scm_pkg::*;
  // ==========================================================
  // signals
  logic        sys_clk_i, rst_i, hsel_i, hwrite_i, hready_w, hreadyout_o, hresp_o;
  logic [11:0] haddr_i;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i, mode_o;
  logic [31:0] hwdata_i, hrdata_o, rd;
  logic        fast_osc_i, slow_osc_i, slow_src_xtal_i, wake_i, halt_i;
  logic        sys_clk_en_o, cpu_clk_en_o, periph_clk_en_o, slow_clk_en_o;
  logic        fast_osc_en_o, slow_osc_en_o, xtal_sel_o, crystal_low_power_o, irq_o;
  logic [4:0]  rc_freq_mhz_o;
  logic [3:0]  osc_cnt;
  int          mismatches, samples_checked, cs, cc, cp, cl, ex;
  assign hready_w = hreadyout_o;
  scm_top #(.LARGE_VARIANT(1'b1)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_w), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .fast_osc_i(fast_osc_i), .slow_osc_i(slow_osc_i),
    .slow_src_xtal_i(slow_src_xtal_i), .wake_i(wake_i), .halt_i(halt_i),
    .sys_clk_en_o(sys_clk_en_o), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .slow_clk_en_o(slow_clk_en_o),
    .fast_osc_en_o(fast_osc_en_o), .slow_osc_en_o(slow_osc_en_o),
    .xtal_sel_o(xtal_sel_o), .crystal_low_power_o(crystal_low_power_o),
    .rc_freq_mhz_o(rc_freq_mhz_o), .mode_o(mode_o), .irq_o(irq_o));
  // small variant on the same bus, read data and strap watched only
  logic [31:0] hrdata_small;
  logic        xtal_small;
  scm_top #(.LARGE_VARIANT(1'b0)) i_dut_small (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_w), .hrdata_o(hrdata_small), .hreadyout_o(), .hresp_o(),
    .fast_osc_i(fast_osc_i), .slow_osc_i(slow_osc_i), .slow_src_xtal_i(slow_src_xtal_i),
    .wake_i(wake_i), .halt_i(halt_i), .sys_clk_en_o(), .cpu_clk_en_o(),
    .periph_clk_en_o(), .slow_clk_en_o(), .fast_osc_en_o(), .slow_osc_en_o(),
    .xtal_sel_o(xtal_small), .crystal_low_power_o(), .rc_freq_mhz_o(), .mode_o(),
    .irq_o());
  // ==========================================================
  // clock and oscillator waveforms: fast period 4 cycles, slow 16
  initial sys_clk_i = 1'b0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    osc_cnt    <= osc_cnt + 4'd1;
    fast_osc_i <= osc_cnt[1];
    slow_osc_i <= osc_cnt[3];
  end
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge sys_clk_i);
    haddr_i  <= a;
    hwrite_i <= w;
    htrans_i <= 2'b10;
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= w ? wd : 32'h0000_0000;
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    check("hresp", {31'd0, hresp_o}, 32'h0000_0000);
  endtask
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask
  task automatic count_en(input int n);
    cs = 0; cc = 0; cp = 0; cl = 0;
    repeat (n) begin
      @(posedge sys_clk_i);
      cs += (sys_clk_en_o === 1'b1);
      cc += (cpu_clk_en_o === 1'b1);
      cp += (periph_clk_en_o === 1'b1);
      cl += (slow_clk_en_o === 1'b1);
    end
  endtask
  task automatic near(input string what, input int seen, input int exp);
    check(what, {31'd0, (seen >= exp - 1) && (seen <= exp + 1)}, 32'h0000_0001);
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic halt_wake(input logic [2:0] opm);
    @(posedge sys_clk_i) halt_i <= 1'b1;
    @(posedge sys_clk_i) halt_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    check("mode_o", {29'd0, mode_o}, {29'd0, opm});
    count_en(256);
    check("cpu_en", cc, 0);
    near("slow_en", cl, 16);
    check("slow_osc_en", {31'd0, slow_osc_en_o}, 32'h0000_0001);
  endtask
  task automatic wake_up();
    @(posedge sys_clk_i) wake_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    wake_i <= 1'b0;
    check("mode_o", {29'd0, mode_o}, {29'd0, `SCM_OPM_FAST});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    repeat (300) @(posedge sys_clk_i);
    rd_chk("mode", `SCM_OFS_MODE, 32'h0000_000F);
    rd_chk("ctrl", `SCM_OFS_CTRL, 32'h0000_0000);
    rd_chk("unmapped", 12'h010, 32'h0000_0000);
    check("xtal_sel", {31'd0, xtal_sel_o}, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_regs();
    logic [4:0] mhz [4];
    mhz = '{5'd8, 5'd12, 5'd16, 5'd8};
    ahb(1'b1, `SCM_OFS_MODE, 32'hFFFF_FFFF);
    rd_chk("mode_ones", `SCM_OFS_MODE, 32'h0000_00EF);
    ahb(1'b1, 12'h010, 32'hFFFF_FFFF);
    rd_chk("unmapped_wr", 12'h010, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, `SCM_OFS_CTRL, 32'h0000_0088 | (i << 4));
      rd_chk("ctrl", `SCM_OFS_CTRL, 32'h0000_0088 | (i << 4));
      check("rc_mhz", {27'd0, rc_freq_mhz_o}, {27'd0, mhz[i]});
      check("xlp", {31'd0, crystal_low_power_o}, 32'h0000_0001);
    end
    ahb(1'b1, `SCM_OFS_CTRL, 32'h0000_00FF);
    rd_chk("ctrl_ones", `SCM_OFS_CTRL, 32'h0000_00B8);
    check("ctrl_small", hrdata_small, 32'h0000_00B0);
    ahb(1'b1, `SCM_OFS_CTRL, 32'h0000_0000);
    $display("test registers done");
  endtask
  task automatic t_divider();
    for (int c = 1; c <= 8; c++) begin
      // c = 8 stands for the undivided select
      ahb(1'b1, `SCM_OFS_MODE, (c == 8) ? 32'h0000_0003 : ((c << 5) | 2));
      repeat (400) @(posedge sys_clk_i);
      count_en(1024);
      ex = (c == 8) ? 256 : (c == 1) ? 64 : 256 >> (8 - c);
      near("sys_en", cs, ex);
      near("cpu_en", cc, ex);
      near("periph_en", cp, ex);
      check("mode_o", {29'd0, mode_o}, (c == 1) ? 32'd1 : 32'd0);
      check("fast_osc_en", {31'd0, fast_osc_en_o}, (c == 1) ? 32'd0 : 32'd1);
    end
    ahb(1'b1, `SCM_OFS_MODE, 32'h0000_0000);
    repeat (300) @(posedge sys_clk_i);
    check("mode_o", {29'd0, mode_o}, 32'd1);
    ahb(1'b1, `SCM_OFS_MODE, 32'h0000_0003);
    repeat (300) @(posedge sys_clk_i);
    $display("test divider done");
  endtask
  task automatic t_sleep();
    ahb(1'b1, `SCM_OFS_IRQ_MASK, 32'h0000_0000);
    ahb(1'b1, `SCM_OFS_IRQ_STAT, 32'h0000_0007);
    ahb(1'b1, `SCM_OFS_MODE, 32'h0000_0001);
    halt_wake(`SCM_OPM_SLEEP);
    check("sys_en", cs, 0);
    check("fast_osc_en", {31'd0, fast_osc_en_o}, 32'h0000_0000);
    rd_chk("mode_sleep", `SCM_OFS_MODE, 32'h0000_0001);
    wake_up();
    repeat (30) @(posedge sys_clk_i);
    rd_chk("fast_rdy_early", `SCM_OFS_MODE, 32'h0000_0009);
    repeat (150) @(posedge sys_clk_i);
    rd_chk("mode_woken", `SCM_OFS_MODE, 32'h0000_000D);
    rd_chk("irq_stat", `SCM_OFS_IRQ_STAT, 32'h0000_0007);
    check("irq_masked", {31'd0, irq_o}, 32'h0000_0000);
    ahb(1'b1, `SCM_OFS_IRQ_MASK, 32'h0000_0004);
    repeat (3) @(posedge sys_clk_i);
    check("irq_on", {31'd0, irq_o}, 32'h0000_0001);
    ahb(1'b1, `SCM_OFS_IRQ_STAT, 32'h0000_0004);
    repeat (3) @(posedge sys_clk_i);
    check("irq_off", {31'd0, irq_o}, 32'h0000_0000);
    rd_chk("irq_stat_w1c", `SCM_OFS_IRQ_STAT, 32'h0000_0003);
    $display("test sleep done");
  endtask
  task automatic t_idle();
    ahb(1'b1, `SCM_OFS_MODE, 32'h0000_0003);
    halt_wake(`SCM_OPM_IDLE_STOP);
    check("sys_en", cs, 0);
    check("periph_en", cp, 0);
    rd_chk("mode_idle_clock_stopped", `SCM_OFS_MODE, 32'h0000_000B);
    wake_up();
    repeat (200) @(posedge sys_clk_i);
    ahb(1'b1, `SCM_OFS_CTRL, 32'h0000_0080);
    halt_wake(`SCM_OPM_IDLE_RUN);
    near("sys_en", cs, 64);
    near("periph_en", cp, 64);
    rd_chk("mode_idle_clock_running", `SCM_OFS_MODE, 32'h0000_000F);
    @(posedge sys_clk_i) halt_i <= 1'b1;
    @(posedge sys_clk_i) halt_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    check("halt_ignored", {29'd0, mode_o}, {29'd0, `SCM_OPM_IDLE_RUN});
    wake_up();
    count_en(64);
    near("cpu_en_woken", cc, 16);
    $display("test idle done");
  endtask
  task automatic t_xtal();
    slow_src_xtal_i <= 1'b1;
    do_reset();
    repeat (600) @(posedge sys_clk_i);
    check("xtal_sel", {31'd0, xtal_sel_o}, 32'h0000_0001);
    check("xtal_small", {31'd0, xtal_small}, 32'h0000_0000);
    rd_chk("xtal_wait", `SCM_OFS_MODE, 32'h0000_0007);
    repeat (2200) @(posedge sys_clk_i);
    rd_chk("xtal_ready", `SCM_OFS_MODE, 32'h0000_000F);
    $display("test crystal done");
  endtask
  // ==========================================================
  // run control
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    mismatches = 0; samples_checked = 0; osc_cnt = 4'd0;
    fast_osc_i = 1'b0; slow_osc_i = 1'b0; slow_src_xtal_i = 1'b0;
    rst_i = 1'b1; hsel_i = 1'b1; haddr_i = 12'h000; htrans_i = 2'b00;
    hwrite_i = 1'b0; hsize_i = 3'b010; hwdata_i = 32'h0000_0000;
    wake_i = 1'b0; halt_i = 1'b0;
    do_reset();
    t_reset();
    t_regs();
    t_divider();
    t_sleep();
    t_idle();
    t_xtal();
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    mismatches++;
    $display("FAIL watchdog expected finish seen timeout");
    end_of_test();
  end
endmodule // testbench

/* verilog/scm_top.sv */
// system clock selection and power mode control with ahb-lite registers
//
// Function
// - high_low_clock_select 1 runs system clock from undivided fast clock.
// - divider codes 000/001 pick slow clock; 010..111 pick fast/64..fast/2.
// - moving system clock to slow source stops the fast oscillator.
// - slow clock source is rc or crystal, fixed by a configuration strap.
// - fast operation divides fast internal rc by 1 to 64.
// - halt with idle_enable low enters sleep; only slow clock keeps running.
// - halt with idle_enable high, keep bit low: idle with system clock stopped.
// - halt with both bits high: idle, system oscillator keeps clocking peripherals.
// - cpu runs only in fast and slow modes; slow clock always on.
// - slow ready reads 0 in sleep; rises after 128 crystal or 2 rc cycles.
// - fast ready cleared at power-on, 0 in sleep/idle-stopped, rises after 16 cycles.
// - fast ready rises 16 fast cycles after power-on; reads before then return 0.
// - mode register bit 4 reads zero.
// - small variant takes slow clock only from internal rc.
// - control keeps bit 7, rc select 5:4, crystal low power bit 3 large only.
// - rc select 00/01/10/11 give 8/12/16/8 mhz.
// - crystal low power 0 quick start, 1 low power; cleared at reset.
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`include "scm_params.svh"
module scm_top
  import scm_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [11:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // oscillator waveforms, strap and wake pin
  input  wire logic        fast_osc_i,
  input  wire logic        slow_osc_i,
  input  wire logic        slow_src_xtal_i,
  input  wire logic        wake_i,
  // cpu halt request, one-cycle pulse
  input  wire logic        halt_i,
  // clock enables, oscillator controls, operating mode and interrupt outputs
  output logic             sys_clk_en_o,
  output logic             cpu_clk_en_o,
  output logic             periph_clk_en_o,
  output logic             slow_clk_en_o,
  output logic             fast_osc_en_o,
  output logic             slow_osc_en_o,
  output logic             xtal_sel_o,
  output logic             crystal_low_power_o,
  output logic      [4:0]  rc_freq_mhz_o,
  output logic      [2:0]  mode_o,
  output logic             irq_o
);

  // ==========================================================
  // helpers
  function automatic scm_src_t req_src(input logic hl, input logic [2:0] div);
    if (hl) begin
      req_src = 3'd0;
    end else if (div[2:1] == 2'b00) begin
      req_src = `SCM_SRC_SLOW;
    end else begin
      req_src = 3'(4'd8 - {1'b0, div});
    end
  endfunction

  function automatic logic div_hit(input logic [5:0] cnt, input scm_src_t k);
    logic [5:0] mask;
    mask = 6'h3F >> (3'd6 - k);
    div_hit = (k <= 3'd6) && ((cnt & mask) == mask);
  endfunction

  // ==========================================================
  // pin synchronisers and edge detect
  logic [2:0] fast_sync_r;
  logic [2:0] slow_sync_r;
  logic [1:0] wake_sync_r;
  logic       fast_tick;
  logic       slow_tick;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fast_sync_r <= 3'b000;
      slow_sync_r <= 3'b000;
      wake_sync_r <= 2'b00;
    end else begin
      fast_sync_r <= {fast_sync_r[1:0], fast_osc_i};
      slow_sync_r <= {slow_sync_r[1:0], slow_osc_i};
      wake_sync_r <= {wake_sync_r[0], wake_i};
    end
  end

  assign fast_tick = fast_sync_r[1] & ~fast_sync_r[2];
  assign slow_tick = slow_sync_r[1] & ~slow_sync_r[2];

  // ==========================================================
  // strap capture
  logic [1:0] strap_sync_r;
  logic       strap_done_r;
  logic       xtal_r;

  // strap synchroniser runs through reset so it is settled at release
  always_ff @(posedge sys_clk_i) begin
    strap_sync_r <= {strap_sync_r[0], slow_src_xtal_i};
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      strap_done_r <= 1'b0;
      xtal_r       <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      xtal_r       <= strap_sync_r[1] & LARGE_VARIANT;
    end
  end

  // ==========================================================
  // registers
  logic [2:0]  div_r;
  logic        idle_en_r;
  logic        hl_sel_r;
  logic        keep_r;
  logic [1:0]  rc_sel_r;
  logic        xlp_r;
  logic [`SCM_IRQ_WIDTH-1:0] irq_stat_r;
  logic [`SCM_IRQ_WIDTH-1:0] irq_mask_r;
  logic        wr_pend_r;
  logic [11:0] wr_addr_r;
  logic        rd_take;
  logic        wr_take;
  logic [`SCM_IRQ_WIDTH-1:0] irq_set;
  logic [`SCM_IRQ_WIDTH-1:0] irq_clr;

  assign rd_take = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
  assign wr_take = hsel_i & htrans_i[1] & hready_i & hwrite_i;
  assign irq_clr = (wr_pend_r && wr_addr_r == `SCM_OFS_IRQ_STAT) ?
                   hwdata_i[`SCM_IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end else begin
      wr_pend_r <= wr_take;
      wr_addr_r <= haddr_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      div_r     <= 3'(`SCM_MODE_RESET >> `SCM_MODE_DIV_LO);
      idle_en_r <= 1'(`SCM_MODE_RESET >> `SCM_MODE_IDLE_EN);
      hl_sel_r  <= 1'(`SCM_MODE_RESET >> `SCM_MODE_HL_SEL);
      keep_r    <= 1'(`SCM_CTRL_RESET >> `SCM_CTRL_KEEP);
      rc_sel_r  <= 2'(`SCM_CTRL_RESET >> `SCM_CTRL_RC_LO);
      xlp_r     <= 1'(`SCM_CTRL_RESET >> `SCM_CTRL_XLP);
      irq_mask_r <= '0;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        `SCM_OFS_MODE: begin
          div_r     <= hwdata_i[`SCM_MODE_DIV_HI:`SCM_MODE_DIV_LO];
          idle_en_r <= hwdata_i[`SCM_MODE_IDLE_EN];
          hl_sel_r  <= hwdata_i[`SCM_MODE_HL_SEL];
        end
        `SCM_OFS_CTRL: begin
          keep_r   <= hwdata_i[`SCM_CTRL_KEEP];
          rc_sel_r <= hwdata_i[`SCM_CTRL_RC_HI:`SCM_CTRL_RC_LO];
          xlp_r    <= hwdata_i[`SCM_CTRL_XLP] & LARGE_VARIANT;
        end
        `SCM_OFS_IRQ_MASK: begin
          irq_mask_r <= hwdata_i[`SCM_IRQ_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // source divider and glitch-free source switch
  scm_state_e state_r;
  scm_src_t   sel_r;
  scm_src_t   req;
  logic [5:0] fdiv_cnt_r;
  logic       fast_en_r;
  logic       fast_rdy_r;
  logic       slow_rdy_r;
  logic [4:0] fast_cnt_r;
  logic [7:0] slow_cnt_r;
  logic       src_tick;
  logic       req_tick;
  logic       req_ready;

  assign req       = req_src(hl_sel_r, div_r);
  assign src_tick  = (sel_r == `SCM_SRC_SLOW) ? slow_tick : (fast_tick & div_hit(fdiv_cnt_r, sel_r));
  assign req_tick  = (req == `SCM_SRC_SLOW) ? slow_tick : (fast_tick & div_hit(fdiv_cnt_r, req));
  assign req_ready = (req == `SCM_SRC_SLOW) ? slow_rdy_r : fast_rdy_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fdiv_cnt_r <= 6'h00;
    end else if (fast_tick) begin
      fdiv_cnt_r <= fdiv_cnt_r + 6'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sel_r <= 3'd0;
    end else if (state_r == ST_RUN && req != sel_r && req_ready && req_tick) begin
      sel_r <= req;
    end
  end

  // ==========================================================
  // power state machine
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= ST_RUN;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (halt_i) begin
            if (!idle_en_r) begin
              state_r <= ST_SLEEP;
            end else if (!keep_r) begin
              state_r <= ST_IDLE_CLOCK_STOPPED;
            end else begin
              state_r <= ST_IDLE_CLOCK_RUNNING;
            end
          end
        end
        default: begin
          if (wake_sync_r[1]) begin
            state_r <= ST_RUN;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // oscillator enables and ready flags
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fast_en_r <= 1'b1;
    end else begin
      case (state_r)
        ST_RUN: fast_en_r <= (req != `SCM_SRC_SLOW) || (sel_r != `SCM_SRC_SLOW);
        ST_IDLE_CLOCK_RUNNING: fast_en_r <= (sel_r != `SCM_SRC_SLOW);
        default: fast_en_r <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !fast_en_r) begin
      fast_cnt_r <= 5'd0;
      fast_rdy_r <= 1'b0;
    end else if (fast_tick && !fast_rdy_r) begin
      fast_cnt_r <= fast_cnt_r + 5'd1;
      fast_rdy_r <= (fast_cnt_r + 5'd1) == `SCM_FAST_STABLE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || state_r == ST_SLEEP) begin
      slow_cnt_r <= 8'd0;
      slow_rdy_r <= 1'b0;
    end else if (slow_tick && !slow_rdy_r) begin
      slow_cnt_r <= slow_cnt_r + 8'd1;
      slow_rdy_r <= (slow_cnt_r + 8'd1) == (xtal_r ? `SCM_XTAL_STABLE : `SCM_RC_STABLE);
    end
  end

  // ==========================================================
  // interrupts, set wins over clear
  logic fast_rdy_d_r;
  logic slow_rdy_d_r;
  logic asleep_d_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fast_rdy_d_r <= 1'b0;
      slow_rdy_d_r <= 1'b0;
      asleep_d_r   <= 1'b0;
    end else begin
      fast_rdy_d_r <= fast_rdy_r;
      slow_rdy_d_r <= slow_rdy_r;
      asleep_d_r   <= (state_r != ST_RUN);
    end
  end

  assign irq_set = {asleep_d_r & (state_r == ST_RUN),
                    slow_rdy_r & ~slow_rdy_d_r,
                    fast_rdy_r & ~fast_rdy_d_r};

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
      irq_o      <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq_o      <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
    end
  end

  // ==========================================================
  // bus read data and response
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (rd_take) begin
        case (haddr_i)
          `SCM_OFS_MODE:
            hrdata_o <= {24'h00_0000, div_r, 1'b0, slow_rdy_r, fast_rdy_r,
                         idle_en_r, hl_sel_r};
          `SCM_OFS_CTRL:
            hrdata_o <= {24'h00_0000, keep_r, 1'b0, rc_sel_r, xlp_r, 3'b000};
          `SCM_OFS_IRQ_STAT: hrdata_o <= {29'h0000_0000, irq_stat_r};
          `SCM_OFS_IRQ_MASK: hrdata_o <= {29'h0000_0000, irq_mask_r};
          default:           hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // clock enables and status outputs
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sys_clk_en_o        <= 1'b0;
      cpu_clk_en_o        <= 1'b0;
      periph_clk_en_o     <= 1'b0;
      slow_clk_en_o       <= 1'b0;
      fast_osc_en_o       <= 1'b1;
      slow_osc_en_o       <= 1'b1;
      xtal_sel_o          <= 1'b0;
      crystal_low_power_o <= 1'b0;
      rc_freq_mhz_o       <= `SCM_RC_MHZ_00;
      mode_o              <= `SCM_OPM_FAST;
    end else begin
      sys_clk_en_o    <= src_tick & (state_r == ST_RUN || state_r == ST_IDLE_CLOCK_RUNNING);
      cpu_clk_en_o    <= src_tick & (state_r == ST_RUN);
      periph_clk_en_o <= src_tick & (state_r == ST_RUN || state_r == ST_IDLE_CLOCK_RUNNING);
      slow_clk_en_o   <= slow_tick;
      fast_osc_en_o   <= fast_en_r;
      slow_osc_en_o   <= 1'b1;
      xtal_sel_o      <= xtal_r;
      crystal_low_power_o <= xlp_r;
      case (rc_sel_r)
        2'b00:   rc_freq_mhz_o <= `SCM_RC_MHZ_00;
        2'b01:   rc_freq_mhz_o <= `SCM_RC_MHZ_01;
        2'b10:   rc_freq_mhz_o <= `SCM_RC_MHZ_10;
        default: rc_freq_mhz_o <= `SCM_RC_MHZ_11;
      endcase
      case (state_r)
        ST_RUN:   mode_o <= (sel_r == `SCM_SRC_SLOW) ? `SCM_OPM_SLOW : `SCM_OPM_FAST;
        ST_SLEEP: mode_o <= `SCM_OPM_SLEEP;
        ST_IDLE_CLOCK_STOPPED: mode_o <= `SCM_OPM_IDLE_STOP;
        default:  mode_o <= `SCM_OPM_IDLE_RUN;
      endcase
    end
  end

  // ==========================================================
  // assertions
  sequence s_halt_run;
    halt_i && state_r == ST_RUN;
  endsequence

  property p_sleep_entry;
    @(posedge sys_clk_i) disable iff (rst_i)
      s_halt_run ##0 !idle_en_r |=> state_r == ST_SLEEP ##1 !slow_rdy_r && !fast_en_r;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

  property p_idle_stop;
    @(posedge sys_clk_i) disable iff (rst_i)
      s_halt_run ##0 idle_en_r && !keep_r |=> state_r == ST_IDLE_CLOCK_STOPPED ##1 !fast_en_r;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("idle stop entry wrong");

  property p_idle_run;
    @(posedge sys_clk_i) disable iff (rst_i)
      s_halt_run ##0 idle_en_r && keep_r |=> state_r == ST_IDLE_CLOCK_RUNNING;
  endproperty
  a_idle_run: assert property (p_idle_run) else $error("idle run entry wrong");

  property p_cpu_off;
    @(posedge sys_clk_i) disable iff (rst_i)
      state_r != ST_RUN |=> !cpu_clk_en_o;
  endproperty
  a_cpu_off: assert property (p_cpu_off) else $error("cpu clocked in low power");

  property p_fast_stop;
    @(posedge sys_clk_i) disable iff (rst_i)
      state_r == ST_RUN && sel_r == `SCM_SRC_SLOW && req == `SCM_SRC_SLOW |=> !fast_en_r;
  endproperty
  a_fast_stop: assert property (p_fast_stop) else $error("fast osc left on");

  property p_fast_rdy_count;
    @(posedge sys_clk_i) disable iff (rst_i)
      $rose(fast_rdy_r) |-> $past(fast_cnt_r) == 5'd15 && fast_en_r;
  endproperty
  a_fast_rdy_count: assert property (p_fast_rdy_count) else $error("fast ready early");

  property p_switch_ready;
    @(posedge sys_clk_i) disable iff (rst_i)
      $changed(sel_r) |-> $past(req_ready) && $past(req_tick) && sel_r == $past(req);
  endproperty
  a_switch_ready: assert property (p_switch_ready) else $error("unsafe source switch");

  property p_bit4_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
      rd_take && haddr_i == `SCM_OFS_MODE |=> hrdata_o[`SCM_MODE_UNUSED] == 1'b0;
  endproperty
  a_bit4_zero: assert property (p_bit4_zero) else $error("bit 4 not zero");

  property p_div_select;
    @(posedge sys_clk_i) disable iff (rst_i)
      !hl_sel_r && div_r[2:1] == 2'b00 |-> req == `SCM_SRC_SLOW;
  endproperty
  a_div_select: assert property (p_div_select) else $error("slow code not decoded");

endmodule // scm_top
